/* File: rtl/aocs_cfg.svh */
`ifndef AOCS_CFG_SVH
`define AOCS_CFG_SVH

// Register addresses of the configuration memory.
`define AOCS_ADDR_MULT_HIGH 4'h9
`define AOCS_ADDR_MULT_LOW 4'hA
`define AOCS_ADDR_LOWER 4'hB
`define AOCS_ADDR_UPPER 4'hC

// Field positions.
`define AOCS_LIMIT_MSB 12
`define AOCS_SWITCH_LSB 6
`define AOCS_MULT_HIGH_MSB 5
`define AOCS_MULT_LOW_MSB 12
`define AOCS_SLOPE_BIT 13

// Reset values of the four registers.
`define AOCS_RST_MULT_HIGH 16'hFFC1
`define AOCS_RST_MULT_LOW 16'h0400
`define AOCS_RST_LOWER 16'h0100
`define AOCS_RST_UPPER 16'h1300

// Output code limits.
`define AOCS_CODE_MIN 13'h0100
`define AOCS_CODE_MAX 13'h1300

`endif

/* File: rtl/aocs_pkg.sv */
package aocs_pkg;

    // Register write request from the configuration port.
    typedef struct packed {
        logic wr;
        logic [3:0] addr;
        logic [15:0] data;
    } aocs_req_t;

    // Stored configuration.
    typedef struct packed {
        logic [15:0] mult_high;
        logic [15:0] mult_low;
        logic [15:0] lower;
        logic [15:0] upper;
    } aocs_cfg_t;

endpackage

/* File: rtl/aocs_scale.sv */
`timescale 1ns/10ps
`include "aocs_cfg.svh"

// Multiplies a 16-bit angle fraction by the 19-bit range multiplier and
// adds the lower limit, registered once.
module aocs_scale
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [15:0] angle,
    input wire logic [18:0] mult,
    input wire logic [12:0] lower,
    output logic [17:0] code
);
    typedef struct packed {
        logic [17:0] code;
    } aocs_scale_state_t;

    aocs_scale_state_t state_reg;
    aocs_scale_state_t state_next;
    logic [34:0] product;

    // Angle (2^-16 units of 180 deg) times multiplier (2^-14 units) gives
    // 2^-30; the code scale is 8192 per unit, so shift right by 17.
    always_comb
    begin
        product = {19'h00000, angle} * {16'h0000, mult};
        state_next = state_reg;
        state_next.code = product[34:17] + {5'h00, lower};
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign code = state_reg.code;
endmodule // aocs_scale

/* File: rtl/aocs_top.sv */
`timescale 1ns/10ps
`include "aocs_cfg.svh"

// How it works
// - The upper limit register keeps a 13-bit output code, valid 256..4864.
// - Upper limit bits 15..13 are written as zero and may read back anything.
// - Multiplier high part sits in bits 5..0, weights 16 down to one half.
// - Multiplier low part continues below, its last bit weighted 2^-14.
// - Low register bits 15..14 are diagnostic level bits, not multiplier.
// - The switch angle is a 10-bit fraction in high register bits 15..6.
// - Rising slope: angle above the switch angle forces the lower limit.
// - Low register bit 13 picks the slope: 0 rising, 1 falling.
module aocs_top
(
    input wire logic core_clk,
    input wire logic reset,
    input wire aocs_pkg::aocs_req_t cfg_req,
    output logic [15:0] cfg_rdata,
    input wire logic [15:0] angle,
    input wire logic angle_valid,
    output logic [12:0] out_code,
    output logic out_valid,
    output logic clamp_active
);
    typedef struct packed {
        aocs_pkg::aocs_cfg_t cfg;
        logic [15:0] rdata;
        logic pend;
        logic above;
        logic [12:0] code;
        logic valid;
        logic clamp;
    } aocs_state_t;

    aocs_state_t state_reg;
    aocs_state_t state_next;
    logic [18:0] mult;
    logic [17:0] scaled;
    logic falling;
    logic [12:0] lower;
    logic [12:0] upper;
    logic [12:0] ramp;
    // Decoded selects and the angle as the scaler sees it.
    logic [15:0] scale_angle;
    logic [3:0] wr_sel;
    logic [3:0] rd_sel;
    logic switch_hit;

    // -------------------------------------------------------------------
    // Helper functions
    // -------------------------------------------------------------------

    // One-hot register select: bit 0 is the high multiplier word, bit 1
    // the low multiplier word, bit 2 the lower limit and bit 3 the upper
    // limit. Writes and reads share it so the two decodes cannot drift.
    function automatic logic [3:0] reg_select
    (
        input logic [3:0] addr
    );
        logic [3:0] sel;
        sel = 4'h0;
        case (addr)
            `AOCS_ADDR_MULT_HIGH: sel = 4'h1;
            `AOCS_ADDR_MULT_LOW: sel = 4'h2;
            `AOCS_ADDR_LOWER: sel = 4'h4;
            `AOCS_ADDR_UPPER: sel = 4'h8;
            default: sel = 4'h0;
        endcase
        return sel;
    endfunction

    // Read mux over the stored words. All sixteen bits come back, so the
    // undefined top bits of the limits echo what was written.
    function automatic logic [15:0] reg_read
    (
        input logic [3:0] sel,
        input aocs_pkg::aocs_cfg_t cfg
    );
        logic [15:0] word;
        word = 16'h0000;
        if (sel[0])
            word = cfg.mult_high;
        if (sel[1])
            word = cfg.mult_low;
        if (sel[2])
            word = cfg.lower;
        if (sel[3])
            word = cfg.upper;
        return word;
    endfunction

    // Caps a scaled code at the upper limit and narrows it to 13 bits.
    // The cap also covers a multiplier programmed larger than the span.
    // Codes above 8191 cannot reach the 13-bit output either.
    function automatic logic [12:0] cap_code
    (
        input logic [17:0] code,
        input logic [12:0] limit
    );
        logic [12:0] capped;
        if (code > {5'h00, limit})
            capped = limit;
        else
            capped = code[12:0];
        return capped;
    endfunction

    // True when the raw angle lies beyond the programmed switch angle.
    // Only the top ten angle bits take part, one switch step each.
    // An all-ones switch code therefore never clamps.
    function automatic logic beyond_switch
    (
        input logic [15:0] raw_angle,
        input logic [15:0] high_word
    );
        return raw_angle[15:6] > high_word[15:`AOCS_SWITCH_LSB];
    endfunction

    // -------------------------------------------------------------------
    // Field extraction
    // -------------------------------------------------------------------
    assign mult = {state_reg.cfg.mult_high[`AOCS_MULT_HIGH_MSB:0],
        state_reg.cfg.mult_low[`AOCS_MULT_LOW_MSB:0]};
    assign falling = state_reg.cfg.mult_low[`AOCS_SLOPE_BIT];
    assign lower = state_reg.cfg.lower[`AOCS_LIMIT_MSB:0];
    assign upper = state_reg.cfg.upper[`AOCS_LIMIT_MSB:0];

    // -------------------------------------------------------------------
    // Decoded selects and angle path
    // -------------------------------------------------------------------

    // A write strobe only reaches the select of a mapped address, so
    // writes elsewhere fall away without touching the stored words.
    // Reads decode the same address every cycle.
    assign wr_sel = cfg_req.wr ? reg_select(cfg_req.addr) : 4'h0;
    assign rd_sel = reg_select(cfg_req.addr);

    // The switch compare uses the raw angle, before any slope mirror.
    assign switch_hit = beyond_switch(angle, state_reg.cfg.mult_high);

    // The scaler registers its product, so it is fed from the live angle:
    // its result then stands exactly at the edge where stage two reads it.
    assign scale_angle = falling ? ~angle : angle;

    // Falling slope mirrors the angle so the ramp runs from upper down.
    aocs_scale u_scale
    (
        .core_clk(core_clk),
        .reset(reset),
        .angle(scale_angle),
        .mult(mult),
        .lower(lower),
        .code(scaled)
    );

    // The scaler output is capped before it can reach the output register.
    assign ramp = cap_code(scaled, upper);

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.valid = 1'b0;
        state_next.pend = 1'b0;
        // Writes store all sixteen bits; the switch angle is used exactly
        // as written, with no attempt to compute it.
        if (wr_sel[0])
            state_next.cfg.mult_high = cfg_req.data;
        if (wr_sel[1])
            state_next.cfg.mult_low = cfg_req.data;
        if (wr_sel[2])
            state_next.cfg.lower = cfg_req.data;
        if (wr_sel[3])
            state_next.cfg.upper = cfg_req.data;
        // Reads return stored bits, so the undefined upper bits echo.
        state_next.rdata = reg_read(rd_sel, state_reg.cfg);
        // Stage one: compare the raw angle to the switch angle while the
        // scaler registers the product for the same angle.
        if (angle_valid)
        begin
            state_next.pend = 1'b1;
            state_next.above = switch_hit;
        end
        // Stage two: product is ready one cycle after capture.
        if (state_reg.pend)
        begin
            state_next.valid = 1'b1;
            state_next.clamp = state_reg.above;
            if (state_reg.above)
                state_next.code = falling ? upper : lower;
            else
                state_next.code = ramp;
        end
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.cfg.mult_high <= `AOCS_RST_MULT_HIGH;
            state_reg.cfg.mult_low <= `AOCS_RST_MULT_LOW;
            state_reg.cfg.lower <= `AOCS_RST_LOWER;
            state_reg.cfg.upper <= `AOCS_RST_UPPER;
        end
        else
            state_reg <= state_next;
    end

    assign cfg_rdata = state_reg.rdata;
    assign out_code = state_reg.code;
    assign out_valid = state_reg.valid;
    assign clamp_active = state_reg.clamp;
endmodule // aocs_top

/* File: verification/aocs_properties.sv */
`timescale 1ns/10ps
// Clamp checks read the live settings from a shadow of the writes.
module aocs_properties
(
    input wire logic core_clk,
    input wire logic reset,
    input wire aocs_pkg::aocs_req_t cfg_req,
    input wire logic [15:0] cfg_rdata,
    input wire logic [15:0] angle,
    input wire logic angle_valid,
    input wire logic [12:0] out_code,
    input wire logic out_valid,
    input wire logic clamp_active
);
    logic [15:0] sh [16];
    logic up;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // No reset: the clamp checks only matter once the bench has programmed.
    always_ff @(posedge core_clk)
        if (cfg_req.wr)
            sh[cfg_req.addr] <= cfg_req.data;
    assign up = angle[15:6] > sh[9][15:6];
    a_out_latency: assert property (
        angle_valid |-> ##2 out_valid)
        else $error("Result late.");
    a_no_stray: assert property (
        out_valid |-> $past(angle_valid, 2))
        else $error("Stray result.");
    a_unmapped_zero: assert property (
        cfg_req.addr < 4'h9 |=> cfg_rdata == 16'h0000)
        else $error("Unmapped read.");
    a_code_bounds: assert property (
        out_valid |-> out_code inside {[13'h0100:13'h1300]})
        else $error("Code out of range.");
    // Reset itself clears the code, so the edge after a reset is exempt.
    a_result_hold: assert property (
        !out_valid && !$past(reset) |-> $stable(out_code))
        else $error("Code moved.");
    a_switch_lower: assert property (
        angle_valid && up && !sh[10][13] |-> ##2 out_code == sh[11][12:0])
        else $error("No lower clamp.");
    a_falling_upper: assert property (
        angle_valid && up && sh[10][13] |-> ##2 out_code == sh[12][12:0])
        else $error("No upper clamp.");
    a_inside_free: assert property (
        angle_valid && !up |-> ##2 !clamp_active && out_code <= sh[12][12:0])
        else $error("Clamped in range.");
    c_clamped: cover property (out_valid && clamp_active);
    c_scaled: cover property (out_valid && !clamp_active);
    c_write: cover property (cfg_req.wr);
endmodule // aocs_properties

bind aocs_top aocs_properties u_props (.core_clk(core_clk), .reset(reset),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .angle(angle),
    .angle_valid(angle_valid), .out_code(out_code), .out_valid(out_valid),
    .clamp_active(clamp_active));

/* File: verification/aocs_prog.sv */
`timescale 1ns/10ps
// Programmer on the configuration port; it changes lines on falling edges.
module aocs_prog
(
    input wire logic core_clk,
    output aocs_pkg::aocs_req_t cfg_req
);
    logic [18:0] m;
    logic [9:0] sw;
    initial cfg_req = '0;
    task automatic put(logic w, logic [3:0] a, logic [15:0] d);
        @(negedge core_clk);
        cfg_req = {w, a, d};
        @(negedge core_clk);
        cfg_req = {1'b0, a, ~d}; // Idle data never repeats the last word.
    endtask
    // Only k of 1 or 2 is supported, k being 180 deg over the range.
    task automatic setup(logic [12:0] l, h, int k, logic s);
        m = 19'((h - l) * 2 * k);
        sw = k == 1 ? 10'h3FF : 10'h300;
        put(1, 4'h9, {sw, m[18:13]});
        put(1, 4'hA, {2'b00, s, m[12:0]});
        put(1, 4'hB, {3'b000, l});
        put(1, 4'hC, {3'b000, h});
    endtask
endmodule // aocs_prog

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] angle = 16'h0000;
    logic angle_valid = 1'b0;
    aocs_pkg::aocs_req_t cfg_req;
    logic [15:0] cfg_rdata;
    logic [12:0] out_code, lo, hi;
    logic out_valid;
    logic clamp_active;
    logic sl;
    logic [15:0] q [$];
    integer seed = 32'hC4D951EB;
    int mismatches = 0;
    int check_count = 0;
    always #20 core_clk = ~core_clk;
    aocs_prog prog (.core_clk(core_clk), .cfg_req(cfg_req));
    aocs_top DUT (.core_clk(core_clk), .reset(reset), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .angle(angle), .angle_valid(angle_valid),
        .out_code(out_code), .out_valid(out_valid),
        .clamp_active(clamp_active));
    task automatic check(logic [15:0] seen, want);
        check_count++;
        if (seen !== want)
        begin
            mismatches++;
            $display("Error %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("%0d checks, %0d mismatches", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // The note is made as the angle goes in; the monitor pops it later.
    task automatic shoot(logic [15:0] a);
        logic [31:0] sc;
        @(negedge core_clk);
        {angle_valid, angle} = {1'b1, a};
        sc = lo + (((sl ? 16'(~a) : a) * prog.m) >> 17);
        // Bit 13 of a note is the clamp flag, as the monitor packs it.
        if (a[15:6] > prog.sw)
            q.push_back({3'b001, sl ? hi : lo});
        else
            q.push_back({3'b000, sc > hi ? hi : sc[12:0]});
    endtask
    // One setting: both sides of the switch angle when k is 2, then random angles.
    task automatic run(logic [12:0] l, h, int k, logic s);
        {lo, hi, sl} = {l, h, s};
        prog.setup(l, h, k, s);
        shoot({prog.sw, 6'h3F});
        shoot({prog.sw + 10'h001, 6'h00});
        for (int i = 0; i < 24; i++)
            shoot(16'($random(seed)));
        @(negedge core_clk);
        angle_valid = 1'b0;
        prog.put(0, 4'h9, 16'h0000);
        check(cfg_rdata, {prog.sw, prog.m[18:13]});
        prog.put(0, 4'hA, 16'h0000);
        check(cfg_rdata, {2'b00, s, prog.m[12:0]});
        $display("Test range %0d slope %0d done", k, s);
    endtask
    initial
    begin
        repeat (3) @(negedge core_clk);
        reset = 1'b0;
        prog.put(1, 4'h3, 16'h1234);
        prog.put(0, 4'h3, 16'h0000);
        check(cfg_rdata, 16'h0000);
        prog.put(0, 4'hC, 16'h0000);
        check(cfg_rdata, 16'h1300);
        $display("Test register defaults done");
        run(13'h0200, 13'h1200, 2, 1'b0);
        run(13'h0100, 13'h1300, 1, 1'b1);
        run(13'h03E8, 13'h0BB8, 2, 1'b1);
        // A second reset must bring the stored words back to defaults.
        @(negedge core_clk);
        reset = 1'b1;
        @(negedge core_clk);
        reset = 1'b0;
        prog.put(0, 4'hA, 16'h0000);
        check(cfg_rdata, 16'h0400);
        prog.put(0, 4'h9, 16'h0000);
        check(cfg_rdata, 16'hFFC1);
        // Every noted result must have come out by now.
        check(16'(q.size()), 16'h0000);
        $display("Test reset and drain done");
        give_verdict();
    end
    initial
    begin
        #100000;
        mismatches++;
        give_verdict();
    end
    // Results are sampled just after the edge that launches them.
    always @(posedge core_clk)
    begin
        #1;
        if (out_valid === 1'b1)
            check({2'b00, clamp_active, out_code}, q.pop_front());
    end
endmodule // testbench
